// File: verilog/jcu_pkg.sv
package jcu_pkg;
  // ==========================================================
  // Register map, byte addresses of aligned 32-bit words
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PHASE = 8'h04;
  localparam logic [7:0] OFF_UOUT = 8'h08;
  localparam logic [7:0] OFF_USER1 = 8'h0C;
  localparam logic [7:0] OFF_USER2 = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // ==========================================================
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RSEL_LSB = 4;
  localparam int CTRL_RREQ_BIT = 8;
  localparam int CTRL_LINK_LSB = 12;
  localparam int PH_HIGH_LSB = 0;
  localparam int PH_LOW_LSB = 8;
  localparam int UO_M1_LSB = 0;
  localparam int UO_M2_LSB = 2;
  localparam int UO_TAP_LSB = 8;
  localparam int CODE_SCALE_LSB = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Timing: one phase tick is one clock period
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 50;
  localparam int HALF_10M_NS = 50;
  localparam int HALF_5M_NS = 100;
  localparam int HALF_1M_NS = 500;
  localparam int HALF_20K_NS = 25000;
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] T_10M = CNT_W'(HALF_10M_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] T_5M = CNT_W'(HALF_5M_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] T_1M = CNT_W'(HALF_1M_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] T_20K = CNT_W'(HALF_20K_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TICK_CYC = CNT_W'(TICK_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
  // ==========================================================
  // Modes
  typedef enum logic [2:0] {CLK_10M, CLK_5M, CLK_1M, CLK_20K, CLK_MANUAL, CLK_ADAPTIVE} jcu_clk_t;
  typedef enum logic [1:0] {RST_BOTH, RST_TEST, RST_SYS} jcu_rsel_t;
  typedef enum logic [1:0] {UO_LOW, UO_HIGH, UO_SW, UO_ACT} jcu_uo_t;
  // Enhanced parallel hosts run in the byte mode
  typedef enum logic [1:0] {LINK_BASIC, LINK_BYTE, LINK_ECP, LINK_NIBBLE} jcu_link_t;

  // Ticks of one phase: scale is two to the code's top bits, times multiplier plus one
  function automatic logic [CNT_W-1:0] ph_ticks(input logic [7:0] code);
    ph_ticks = CNT_W'((CNT_W'(code[CODE_SCALE_LSB-1:0]) + CNT_ONE) << code[7:CODE_SCALE_LSB]) * TICK_CYC;
  endfunction : ph_ticks
endpackage : jcu_pkg

// File: verilog/jcu_unit.sv
`timescale 1ns/1ps
// ==========================================================
// Function
// - High phase lasts 50 ns times scale times multiplier plus one; low likewise.
// - A period is one high phase then one low phase.
// - Phase code is 8 bits: top three scale, low five multiplier.
// - Multiplier comes from the low five bits, 0 to 31.
// - Fixed rates of 10 MHz, 5 MHz, 1 MHz and 20 kHz are offered.
// - An adaptive clocking option is offered.
// - Adaptive mode paces each clock edge on the returned target clock.
// - Reset request asserts both lines, test reset alone, or system reset alone.
// - Two user outputs, each forcible constantly low or high.
// - Each user output may follow its own software write register.
// - Output 1 may be high while the selected tap is downloading.
// - Output 2 may be high while the selected tap is executing.
// - Activity modes follow one selectable tap position.
// - A new user output setting reaches the pin one cycle after the register takes it.
// - Two user inputs are sampled and reported to software.
// - Host link supports basic, byte bidirectional and block transfer modes.
// - Host link also supports a reduced 4-bit mode.
module jcu_unit #(
  parameter int ADDR_W = 8,
  parameter int TAP_W = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Debug activity per tap, same clock
  input wire logic [(1<<TAP_W)-1:0] download_busy,
  input wire logic [(1<<TAP_W)-1:0] exec_busy,
  // Target side
  output logic test_clock,
  input wire logic returned_test_clock,
  output logic test_logic_reset_n,
  output logic system_reset_n,
  output logic [1:0] user_out,
  input wire logic [1:0] user_in,
  // Host link mode
  output logic [1:0] host_link_mode
);
  // ==========================================================
  // State
  typedef struct packed {
    jcu_pkg::jcu_clk_t clk_mode;
    logic [7:0] hi_code;
    logic [7:0] lo_code;
    jcu_pkg::jcu_rsel_t rst_sel;
    logic rst_req;
    jcu_pkg::jcu_link_t link_mode;
    jcu_pkg::jcu_uo_t u1_mode;
    jcu_pkg::jcu_uo_t u2_mode;
    logic u1_sw;
    logic u2_sw;
    logic [TAP_W-1:0] tap_sel;
    logic tck;
    logic [jcu_pkg::CNT_W-1:0] cnt;
    logic tl_rst_n;
    logic sys_rst_n;
    logic [1:0] uout;
    logic rt_a;
    logic rt_b;
    logic [1:0] ui_a;
    logic [1:0] ui_b;
    logic aw_ok;
    logic w_ok;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } jcu_state_t;

  jcu_state_t q;
  jcu_state_t d;
  logic [jcu_pkg::CNT_W-1:0] hi_t;
  logic [jcu_pkg::CNT_W-1:0] lo_t;
  logic adaptive;
  logic [31:0] wr_word;

  // Register view, shared by reads and by byte-lane merging of writes
  function automatic logic [31:0] reg_word(input jcu_state_t s, input logic [ADDR_W-1:0] a);
    reg_word = 32'h0;
    if (a == ADDR_W'(jcu_pkg::OFF_CTRL)) begin
      reg_word[jcu_pkg::CTRL_MODE_LSB +: 3] = s.clk_mode;
      reg_word[jcu_pkg::CTRL_RSEL_LSB +: 2] = s.rst_sel;
      reg_word[jcu_pkg::CTRL_RREQ_BIT] = s.rst_req;
      reg_word[jcu_pkg::CTRL_LINK_LSB +: 2] = s.link_mode;
    end else if (a == ADDR_W'(jcu_pkg::OFF_PHASE)) begin
      reg_word[jcu_pkg::PH_HIGH_LSB +: 8] = s.hi_code;
      reg_word[jcu_pkg::PH_LOW_LSB +: 8] = s.lo_code;
    end else if (a == ADDR_W'(jcu_pkg::OFF_UOUT)) begin
      reg_word[jcu_pkg::UO_M1_LSB +: 2] = s.u1_mode;
      reg_word[jcu_pkg::UO_M2_LSB +: 2] = s.u2_mode;
      reg_word[jcu_pkg::UO_TAP_LSB +: TAP_W] = s.tap_sel;
    end else if (a == ADDR_W'(jcu_pkg::OFF_USER1)) begin
      reg_word[0] = s.u1_sw;
    end else if (a == ADDR_W'(jcu_pkg::OFF_USER2)) begin
      reg_word[0] = s.u2_sw;
    end else if (a == ADDR_W'(jcu_pkg::OFF_STATUS)) begin
      reg_word[5:0] = {s.uout, s.ui_b, s.rt_b, s.tck};
    end
  endfunction : reg_word

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = a == ADDR_W'(jcu_pkg::OFF_CTRL) || a == ADDR_W'(jcu_pkg::OFF_PHASE) ||
      a == ADDR_W'(jcu_pkg::OFF_UOUT) || a == ADDR_W'(jcu_pkg::OFF_USER1) ||
      a == ADDR_W'(jcu_pkg::OFF_USER2) || a == ADDR_W'(jcu_pkg::OFF_STATUS);
  endfunction : is_mapped

  function automatic logic uo_val(input jcu_pkg::jcu_uo_t m, input logic sw, input logic act);
    unique case (m)
      jcu_pkg::UO_LOW: uo_val = 1'h0;
      jcu_pkg::UO_HIGH: uo_val = 1'h1;
      jcu_pkg::UO_SW: uo_val = sw;
      jcu_pkg::UO_ACT: uo_val = act;
    endcase
  endfunction : uo_val

  // ==========================================================
  // Handshakes, frozen with the clock enable so nothing is taken unseen
  assign s_axi_awready = ce && !q.aw_ok;
  assign s_axi_wready = ce && !q.w_ok;
  assign s_axi_arready = ce && !q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign test_clock = q.tck;
  assign test_logic_reset_n = q.tl_rst_n;
  assign system_reset_n = q.sys_rst_n;
  assign user_out = q.uout;
  assign host_link_mode = q.link_mode;
  assign adaptive = q.clk_mode == jcu_pkg::CLK_ADAPTIVE;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    hi_t = jcu_pkg::ph_ticks(q.hi_code);
    lo_t = jcu_pkg::ph_ticks(q.lo_code);
    unique case (q.clk_mode)
      jcu_pkg::CLK_10M: begin hi_t = jcu_pkg::T_10M; lo_t = jcu_pkg::T_10M; end
      jcu_pkg::CLK_5M: begin hi_t = jcu_pkg::T_5M; lo_t = jcu_pkg::T_5M; end
      jcu_pkg::CLK_1M: begin hi_t = jcu_pkg::T_1M; lo_t = jcu_pkg::T_1M; end
      jcu_pkg::CLK_20K: begin hi_t = jcu_pkg::T_20K; lo_t = jcu_pkg::T_20K; end
      default: begin end
    endcase
    // Synchronisers
    d.rt_a = returned_test_clock;
    d.rt_b = q.rt_a;
    d.ui_a = user_in;
    d.ui_b = q.ui_a;
    // Phase counter; adaptive mode also waits for the target to echo the edge
    if (q.cnt != '0) begin
      d.cnt = q.cnt - jcu_pkg::CNT_ONE;
    end else if (!adaptive || q.rt_b == q.tck) begin
      d.tck = !q.tck;
      d.cnt = (q.tck ? lo_t : hi_t) - jcu_pkg::CNT_ONE;
    end
    // Target resets
    d.tl_rst_n = !(q.rst_req && q.rst_sel != jcu_pkg::RST_SYS);
    d.sys_rst_n = !(q.rst_req && q.rst_sel != jcu_pkg::RST_TEST);
    // User outputs follow their settings one cycle later
    d.uout[0] = uo_val(q.u1_mode, q.u1_sw, download_busy[q.tap_sel]);
    d.uout[1] = uo_val(q.u2_mode, q.u2_sw, exec_busy[q.tap_sel]);
    // Write channel
    if (s_axi_awvalid && !q.aw_ok) begin
      d.aw_ok = 1'h1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_ok) begin
      d.w_ok = 1'h1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    wr_word = reg_word(q, q.awaddr);
    for (int i = 0; i < 4; i++) begin
      if (q.wstrb[i]) wr_word[8*i +: 8] = q.wdata[8*i +: 8];
    end
    if (q.aw_ok && q.w_ok && !q.bvalid) begin
      d.aw_ok = 1'h0;
      d.w_ok = 1'h0;
      d.bvalid = 1'h1;
      d.bresp = is_mapped(q.awaddr) ? jcu_pkg::RESP_OKAY : jcu_pkg::RESP_SLVERR;
      if (q.awaddr == ADDR_W'(jcu_pkg::OFF_CTRL)) begin
        d.clk_mode = jcu_pkg::jcu_clk_t'(wr_word[jcu_pkg::CTRL_MODE_LSB +: 3]);
        d.rst_sel = jcu_pkg::jcu_rsel_t'(wr_word[jcu_pkg::CTRL_RSEL_LSB +: 2]);
        d.rst_req = wr_word[jcu_pkg::CTRL_RREQ_BIT];
        d.link_mode = jcu_pkg::jcu_link_t'(wr_word[jcu_pkg::CTRL_LINK_LSB +: 2]);
      end else if (q.awaddr == ADDR_W'(jcu_pkg::OFF_PHASE)) begin
        d.hi_code = wr_word[jcu_pkg::PH_HIGH_LSB +: 8];
        d.lo_code = wr_word[jcu_pkg::PH_LOW_LSB +: 8];
      end else if (q.awaddr == ADDR_W'(jcu_pkg::OFF_UOUT)) begin
        d.u1_mode = jcu_pkg::jcu_uo_t'(wr_word[jcu_pkg::UO_M1_LSB +: 2]);
        d.u2_mode = jcu_pkg::jcu_uo_t'(wr_word[jcu_pkg::UO_M2_LSB +: 2]);
        d.tap_sel = wr_word[jcu_pkg::UO_TAP_LSB +: TAP_W];
      end else if (q.awaddr == ADDR_W'(jcu_pkg::OFF_USER1)) begin
        d.u1_sw = wr_word[0];
      end else if (q.awaddr == ADDR_W'(jcu_pkg::OFF_USER2)) begin
        d.u2_sw = wr_word[0];
      end
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'h0;
    // Read channel
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'h1;
      d.rdata = reg_word(q, s_axi_araddr);
      d.rresp = is_mapped(s_axi_araddr) ? jcu_pkg::RESP_OKAY : jcu_pkg::RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'h0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.tl_rst_n <= 1'h1;
      q.sys_rst_n <= 1'h1;
    end else if (ce) begin
      q <= d;
    end
  end

  // ==========================================================
  // Checks
  a_phase_hold: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.cnt != '0 |=> q.tck == $past(q.tck)) else $error("Clock moved inside a phase");
  a_phase_reload: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.cnt == '0 && !adaptive && !q.tck |=> q.tck && q.cnt == $past(hi_t) - jcu_pkg::CNT_ONE)
    else $error("High phase not reloaded");
  a_manual_ticks: assert property (@(posedge clock) disable iff (!arst_n)
    q.clk_mode == jcu_pkg::CLK_MANUAL |-> hi_t == ((13'(q.hi_code[4:0]) + 13'h0001) << q.hi_code[7:5]))
    else $error("Phase code decoded wrong");
  a_adaptive_wait: assert property (@(posedge clock) disable iff (!arst_n)
    ce && adaptive && q.rt_b != q.tck |=> q.tck == $past(q.tck)) else $error("Edge not paced by return clock");
  a_reset_test: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.rst_req && q.rst_sel == jcu_pkg::RST_TEST |=> !test_logic_reset_n && system_reset_n)
    else $error("Test reset alone not asserted");
  a_reset_idle: assert property (@(posedge clock) disable iff (!arst_n)
    ce && !q.rst_req ##1 ce && !q.rst_req |-> test_logic_reset_n && system_reset_n)
    else $error("Reset line asserted without request");
  a_user_forced: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.u2_mode == jcu_pkg::UO_HIGH |=> user_out[1]) else $error("Forced high output low");
  a_user_soft: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.u1_mode == jcu_pkg::UO_SW |=> user_out[0] == $past(q.u1_sw)) else $error("Output 1 ignores write");
  a_download_bit: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.u1_mode == jcu_pkg::UO_ACT |=> user_out[0] == $past(download_busy[q.tap_sel]))
    else $error("Output 1 not tracking download");
  a_exec_bit: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.u2_mode == jcu_pkg::UO_ACT |=> user_out[1] == $past(exec_busy[q.tap_sel]))
    else $error("Output 2 not tracking execution");
  a_phase_low: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.cnt == '0 && !adaptive && q.tck |=> !q.tck && q.cnt == $past(lo_t) - jcu_pkg::CNT_ONE)
    else $error("Low phase not reloaded");
  a_low_ticks: assert property (@(posedge clock) disable iff (!arst_n)
    q.clk_mode == jcu_pkg::CLK_MANUAL |-> lo_t == ((13'(q.lo_code[4:0]) + 13'h0001) << q.lo_code[7:5]))
    else $error("Low phase code decoded wrong");
  a_preset_rate: assert property (@(posedge clock) disable iff (!arst_n)
    q.clk_mode == jcu_pkg::CLK_1M |-> hi_t == jcu_pkg::T_1M && lo_t == jcu_pkg::T_1M)
    else $error("Preset phase length wrong");
  a_adaptive_edge: assert property (@(posedge clock) disable iff (!arst_n)
    ce && adaptive && q.cnt == '0 && q.rt_b == q.tck |=> q.tck != $past(q.tck))
    else $error("Echoed edge not followed");
  a_reset_both: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.rst_req && q.rst_sel == jcu_pkg::RST_BOTH |=> !test_logic_reset_n && !system_reset_n)
    else $error("Both resets not asserted");
  a_reset_sys: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.rst_req && q.rst_sel == jcu_pkg::RST_SYS |=> test_logic_reset_n && !system_reset_n)
    else $error("System reset alone not asserted");
  a_user_low: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.u1_mode == jcu_pkg::UO_LOW |=> !user_out[0])
    else $error("Forced low output 1 high");
  a_user2_low: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.u2_mode == jcu_pkg::UO_LOW |=> !user_out[1])
    else $error("Forced low output 2 high");
  a_user1_high: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.u1_mode == jcu_pkg::UO_HIGH |=> user_out[0])
    else $error("Forced high output 1 low");
  a_user2_soft: assert property (@(posedge clock) disable iff (!arst_n)
    ce && q.u2_mode == jcu_pkg::UO_SW |=> user_out[1] == $past(q.u2_sw))
    else $error("Output 2 ignores write");
endmodule : jcu_unit

// File: verif/jcu_target_model.sv
`timescale 1ns/1ps
// ==========================================================
// Target side: echoes the test clock through its processor clock
module jcu_target_model #(
  parameter int DELAY = 1
) (
  // Target processor clock and test pins
  input wire logic cpu_clock,
  input wire logic stall,
  input wire logic test_clock,
  input wire logic test_logic_reset_n,
  input wire logic system_reset_n,
  // Echo and reset state
  output logic returned_test_clock,
  output logic tap_in_reset,
  output logic cpu_in_reset
);
  logic [7:0] pipe_q = 8'h00;
  // A stall stands for a sleeping core: the echo freezes
  always_ff @(posedge cpu_clock) if (!stall) pipe_q <= {pipe_q[6:0], test_clock};
  assign returned_test_clock = pipe_q[DELAY-1];
  // Test reset clears tap logic only, system reset the core only
  assign tap_in_reset = !test_logic_reset_n;
  assign cpu_in_reset = !system_reset_n;
endmodule : jcu_target_model

// File: verif/jcu_unit_tb.sv
`timescale 1ns/1ps
module jcu_unit_tb;
  // ==========================================================
  // Stimulus and observed pins
  logic clock = 1'b0;
  logic cpu_clock = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [15:0] dl_busy = 16'h0000;
  logic [15:0] ex_busy = 16'h0000;
  logic [1:0] uin = 2'h0;
  logic stall = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tck, ret_clk, tl_rst_n, sys_rst_n, tap_rst, cpu_rst;
  logic [1:0] bresp, rresp, uout, link;
  logic [31:0] rdata;
  int num_errors = 0;
  int compares = 0;
  jcu_unit jcu_unit_inst (.clock(clock), .arst_n(arst_n), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .download_busy(dl_busy), .exec_busy(ex_busy),
    .test_clock(tck), .returned_test_clock(ret_clk), .test_logic_reset_n(tl_rst_n), .system_reset_n(sys_rst_n),
    .user_out(uout), .user_in(uin), .host_link_mode(link));
  jcu_target_model jcu_target_model_inst (.cpu_clock(cpu_clock), .stall(stall), .test_clock(tck),
    .test_logic_reset_n(tl_rst_n), .system_reset_n(sys_rst_n), .returned_test_clock(ret_clk), .tap_in_reset(tap_rst),
    .cpu_in_reset(cpu_rst));
  initial forever #25 clock = ~clock;
  initial forever #200 cpu_clock = ~cpu_clock;
  // ==========================================================
  // Reporting and bus cycles
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    compares++;
    if (seen !== expected) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, expected);
    end
  endtask : check
  task automatic print_verdict;
    $display("Mismatches %0d in %0d compares", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic give_up;
    num_errors++;
    print_verdict();
  endtask : give_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && !bvalid; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    if (n == 40) give_up();
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && !rvalid; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end
    if (n == 40) give_up();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // Outputs are registered behind the register, so let a few edges land
  task automatic settle;
    repeat (4) @(negedge clock);
  endtask : settle
  // ==========================================================
  // Test clock timing, sampled on the falling edge away from updates
  task automatic wait_lvl(input logic v, output int n);
    for (n = 0; n < 2000; n++) begin
      @(negedge clock);
      if (tck === v) break;
    end
    if (n == 2000) give_up();
  endtask : wait_lvl
  // Skips up to two periods so a mode change never yields a mixed phase
  task automatic measure(output int hi, output int lo);
    int n;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    hi = n + 1;
    wait_lvl(1'b1, n);
    lo = n + 1;
  endtask : measure
  // ==========================================================
  // Scenarios
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    rd(jcu_pkg::OFF_CTRL, d, r);
    check(d, 32'h0);
    rd(8'h20, d, r);
    check(d, 32'h0);
    check(32'(r), 32'(jcu_pkg::RESP_SLVERR));
    wr(jcu_pkg::OFF_STATUS, 32'hFF, r);
    check(32'(r), 32'(jcu_pkg::RESP_OKAY));
    wr(jcu_pkg::OFF_PHASE, 32'h1234, r);
    wstrb <= 4'h1;
    wr(jcu_pkg::OFF_PHASE, 32'hFFFF_FF56, r);
    wstrb <= 4'hF;
    rd(jcu_pkg::OFF_PHASE, d, r);
    check(d, 32'h0000_1256);
    @(posedge clock);
    ce <= 1'b0;
    @(negedge clock);
    check(32'(arready), 32'h0);
    @(posedge clock);
    ce <= 1'b1;
  endtask : t_bus
  task automatic t_presets;
    logic [12:0] t [4] = '{jcu_pkg::T_10M, jcu_pkg::T_5M, jcu_pkg::T_1M, jcu_pkg::T_20K};
    logic [1:0] r;
    int hi, lo, k;
    for (k = 0; k < 4; k++) begin
      wr(jcu_pkg::OFF_CTRL, 32'(k), r);
      measure(hi, lo);
      check(32'(hi), 32'(t[k]));
      check(32'(lo), 32'(t[k]));
    end
  endtask : t_presets
  task automatic t_manual;
    logic [1:0] r;
    int hi, lo, s;
    wr(jcu_pkg::OFF_CTRL, 32'h4, r);
    for (s = 0; s < 8; s++) begin
      wr(jcu_pkg::OFF_PHASE, {16'h0, 3'(s), 5'h00, 3'(s), 5'h01}, r);
      measure(hi, lo);
      check(32'(hi), 32'(2 << s));
      check(32'(lo), 32'(1 << s));
    end
    wr(jcu_pkg::OFF_PHASE, 32'h0000_001F, r);
    measure(hi, lo);
    check(32'(hi), 32'd32);
    check(32'(lo), 32'd1);
  endtask : t_manual
  task automatic t_adaptive;
    logic [1:0] r;
    logic v;
    int hi, lo;
    wr(jcu_pkg::OFF_PHASE, 32'h0, r);
    wr(jcu_pkg::OFF_CTRL, 32'h5, r);
    measure(hi, lo);
    check(32'(hi >= 2 && lo >= 2), 32'h1);
    @(posedge clock);
    stall <= 1'b1;
    repeat (40) @(negedge clock);
    v = tck;
    repeat (60) @(negedge clock);
    check(32'(tck), 32'(v));
    @(posedge clock);
    stall <= 1'b0;
    measure(hi, lo);
    check(32'(lo >= 2), 32'h1);
  endtask : t_adaptive
  task automatic t_resets;
    logic [7:0] tbl = 8'hDB;
    logic [1:0] r;
    int k;
    for (k = 0; k < 4; k++) begin
      wr(jcu_pkg::OFF_CTRL, 32'h100 | 32'(k << 4) | 32'(k << 12), r);
      settle();
      check(32'({tap_rst, cpu_rst}), 32'(tbl[2*k+:2]));
      check(32'(link), 32'(k));
      wr(jcu_pkg::OFF_CTRL, 32'(k << 12), r);
      settle();
      check(32'({tl_rst_n, sys_rst_n}), 32'h3);
    end
  endtask : t_resets
  task automatic uo(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    logic [1:0] r;
    wr(a, v, r);
    settle();
    check(32'(uout), 32'(e));
  endtask : uo
  task automatic t_user_out;
    uo(jcu_pkg::OFF_UOUT, 32'h304, 2'h2);
    uo(jcu_pkg::OFF_UOUT, 32'h301, 2'h1);
    uo(jcu_pkg::OFF_UOUT, 32'h30A, 2'h0);
    uo(jcu_pkg::OFF_USER2, 32'h1, 2'h2);
    uo(jcu_pkg::OFF_USER1, 32'h1, 2'h3);
    @(posedge clock);
    dl_busy <= 16'h0004;
    ex_busy <= 16'h0008;
    uo(jcu_pkg::OFF_UOUT, 32'h30F, 2'h2);
    @(posedge clock);
    dl_busy <= 16'h0008;
    ex_busy <= 16'h0004;
    settle();
    check(32'(uout), 32'h1);
  endtask : t_user_out
  task automatic t_user_in;
    logic [31:0] d;
    logic [1:0] r;
    int k;
    for (k = 1; k < 3; k++) begin
      @(posedge clock);
      uin <= 2'(k);
      settle();
      rd(jcu_pkg::OFF_STATUS, d, r);
      check(32'(d[3:2]), 32'(k));
    end
  endtask : t_user_in
  initial begin
    repeat (3) @(posedge clock);
    check(32'({tck, tl_rst_n, sys_rst_n, uout}), 32'h0C);
    @(posedge clock);
    arst_n <= 1'b1;
    t_bus();
    t_presets();
    t_manual();
    t_adaptive();
    t_resets();
    t_user_out();
    t_user_in();
    print_verdict();
  end
endmodule : jcu_unit_tb
